// ---- logic/ros_pkg.sv ----
/*
  ros_pkg: constants and types shared by the remappable output select block.
  Assumes a 32-bit APB with 12 address bits; one register per aligned word.
*/
package ros_pkg;

  localparam int ROS_NUM_PINS = 10;
  localparam int ROS_NUM_OUT_REGS = 5;
  localparam int ROS_FN_W = 5;
  localparam int ROS_NUM_FUNCS = 32;
  localparam int ROS_ADDR_W = 12;

  // field positions inside an output-select register
  localparam int ROS_HI_LSB = 8;
  localparam int ROS_LO_LSB = 0;

  // status register field positions
  localparam int ROS_STAT_DRIVE_LSB = 0;
  localparam int ROS_STAT_LEVEL_LSB = 16;

  // register byte offsets
  localparam logic [ROS_ADDR_W-1:0] ROS_OFF_OUT_PINS_0_1 = 12'h000;
  localparam logic [ROS_ADDR_W-1:0] ROS_OFF_OUT_PINS_2_3 = 12'h004;
  localparam logic [ROS_ADDR_W-1:0] ROS_OFF_OUT_PINS_4_5 = 12'h008;
  localparam logic [ROS_ADDR_W-1:0] ROS_OFF_OUT_PINS_6_7 = 12'h00C;
  localparam logic [ROS_ADDR_W-1:0] ROS_OFF_OUT_PINS_8_9 = 12'h010;
  localparam logic [ROS_ADDR_W-1:0] ROS_OFF_INPUT_SELECT = 12'h014;
  localparam logic [ROS_ADDR_W-1:0] ROS_OFF_STATUS = 12'h018;

  // reset values
  localparam logic [15:0] ROS_OUT_RESET = 16'h0000;
  localparam logic [4:0] ROS_FN_RESET = 5'h00;
  localparam logic [4:0] ROS_IN_SEL_RESET = 5'h1F;

  // implemented bits of an output-select register
  localparam logic [15:0] ROS_OUT_IMPL_MASK = 16'h1F1F;

  // function numbers that have a peripheral behind them; code 0 never does
  localparam logic [31:0] ROS_FUNC_IMPL = 32'h001F_FFFE;

  typedef logic [ROS_FN_W-1:0] ros_fn_t;

  typedef enum logic {
    ROS_APB_IDLE,
    ROS_APB_ACCESS
  } ros_apb_state_t;

endpackage

// ---- logic/ros_sel_if.sv ----
/*
  ros_sel_if: carries the per-pin function selects from the register file to
  the pin router. Both ends sit on the same pclk domain.
*/
`timescale 1ns/1ps
interface ros_sel_if;
  import ros_pkg::*;

  logic [ROS_NUM_PINS-1:0][ROS_FN_W-1:0] sel;
  logic [ROS_NUM_PINS-1:0] drive_active;

  modport ctl (output sel, input drive_active);
  modport route (input sel, output drive_active);
endinterface

// ---- logic/ros_pin_route.sv ----
/*
  ros_pin_route: per-pin output crossbar; picks a peripheral output by
  function number, or hands the pin back to its port logic.
  Assumes peripheral and port signals come from pclk logic.
*/
`timescale 1ns/1ps
module ros_pin_route
  import ros_pkg::*;
(
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  ros_sel_if.route sel_if, // selects in, drive state out
  input wire logic [ROS_NUM_FUNCS-1:0] periph_data, // peripheral outputs by number
  input wire logic [ROS_NUM_PINS-1:0] port_out, // ordinary port data
  input wire logic [ROS_NUM_PINS-1:0] port_oe, // ordinary port enable
  output logic [ROS_NUM_PINS-1:0] pin_out, // pin data
  output logic [ROS_NUM_PINS-1:0] pin_oe // pin enable, high drives
);
  import ros_pkg::*;

  logic [ROS_NUM_PINS-1:0] act_ff;

  genvar p;
  generate
    for (p = 0; p < ROS_NUM_PINS; p++) begin : g_pin
      logic fn_valid;
      // code 0 and unassigned codes leave the pin to port logic
      assign fn_valid = ROS_FUNC_IMPL[sel_if.sel[p]];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_out[p] <= 1'b0;
          pin_oe[p] <= 1'b0;
          act_ff[p] <= 1'b0;
        end else begin
          pin_out[p] <= fn_valid ? periph_data[sel_if.sel[p]] : port_out[p];
          pin_oe[p] <= fn_valid | port_oe[p];
          act_ff[p] <= fn_valid;
        end
      end
    end
  endgenerate

  assign sel_if.drive_active = act_ff;
endmodule // ros_pin_route

// ---- logic/ros_top.sv ----
/*
  ros_top: remappable output select block with an APB register file.
  Five output-select registers route peripheral outputs onto pins 0..9;
  one input-select field routes a pin back to a peripheral input.
  Assumes a single pclk domain; pin inputs are asynchronous.

*/
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
module ros_top
  import ros_pkg::*;
(
  input wire logic pclk, // system clock, 200 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction, high writes
  input wire logic [ROS_ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic [ROS_NUM_FUNCS-1:0] periph_data, // peripheral outputs
  input wire logic [ROS_NUM_PINS-1:0] port_out, // ordinary port data
  input wire logic [ROS_NUM_PINS-1:0] port_oe, // ordinary port enable
  input wire logic [ROS_NUM_PINS-1:0] pin_in, // pin levels, asynchronous
  output logic [ROS_NUM_PINS-1:0] pin_out, // pin data
  output logic [ROS_NUM_PINS-1:0] pin_oe, // pin enable, high drives
  output logic periph_in // routed peripheral input
);
  import ros_pkg::*;

  // bus state
  ros_apb_state_t state_ff;
  ros_apb_state_t nxt_state;
  logic pready_ff;
  logic nxt_pready;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  // register contents
  logic [ROS_NUM_PINS-1:0][ROS_FN_W-1:0] sel_ff;
  logic [ROS_FN_W-1:0] in_sel_ff;

  // pin input synchroniser and routed input
  logic [ROS_NUM_PINS-1:0] pin_meta_ff;
  logic [ROS_NUM_PINS-1:0] pin_sync_ff;
  logic periph_in_ff;
  logic nxt_periph_in;

  // decode
  logic word_aligned;
  logic [ROS_ADDR_W-1:0] word_addr;
  logic hit_out;
  logic hit_in_sel;
  logic hit_status;
  logic mapped;
  logic setup_phase;
  logic access_done;
  logic wr_fire;
  logic [2:0] out_idx;
  logic [15:0] out_word;
  logic [31:0] status_word;

  ros_sel_if sel_bus ();

  // pin router

  assign sel_bus.sel = sel_ff;

  ros_pin_route u_route (
    .pclk(pclk),
    .presetn(presetn),
    .sel_if(sel_bus),
    .periph_data(periph_data),
    .port_out(port_out),
    .port_oe(port_oe),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  // address decode

  assign word_aligned = (paddr[1:0] == 2'b00);
  assign word_addr = {paddr[ROS_ADDR_W-1:2], 2'b00};

  always_comb begin
    hit_out = 1'b0;
    out_idx = 3'd0;
    unique case (word_addr)
      ROS_OFF_OUT_PINS_0_1: begin
        hit_out = 1'b1;
        out_idx = 3'd0;
      end
      ROS_OFF_OUT_PINS_2_3: begin
        hit_out = 1'b1;
        out_idx = 3'd1;
      end
      ROS_OFF_OUT_PINS_4_5: begin
        hit_out = 1'b1;
        out_idx = 3'd2;
      end
      ROS_OFF_OUT_PINS_6_7: begin
        hit_out = 1'b1;
        out_idx = 3'd3;
      end
      ROS_OFF_OUT_PINS_8_9: begin
        hit_out = 1'b1;
        out_idx = 3'd4;
      end
      default: begin
        hit_out = 1'b0;
        out_idx = 3'd0;
      end
    endcase
  end

  assign hit_in_sel = (word_addr == ROS_OFF_INPUT_SELECT);
  assign hit_status = (word_addr == ROS_OFF_STATUS);
  assign mapped = word_aligned & (hit_out | hit_in_sel | hit_status);

  // apb handshake: answer with no wait state

  assign setup_phase = psel & ~penable;
  assign access_done = (state_ff == ROS_APB_ACCESS) & psel & penable & pready_ff;
  // status is read-only, so a write to it is simply dropped
  assign wr_fire = access_done & pwrite & mapped;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ROS_APB_IDLE: begin
        if (setup_phase) begin
          nxt_state = ROS_APB_ACCESS;
        end
      end
      ROS_APB_ACCESS: begin
        if (access_done) begin
          nxt_state = ROS_APB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ROS_APB_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ready and error are set up in the setup cycle, dropped after the access
  assign nxt_pready = (state_ff == ROS_APB_IDLE) & setup_phase;
  assign nxt_pslverr = (state_ff == ROS_APB_IDLE) & setup_phase & ~mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // read data

  always_comb begin
    out_word = ROS_OUT_RESET;
    out_word[ROS_HI_LSB +: ROS_FN_W] = sel_ff[2 * out_idx + 1];
    out_word[ROS_LO_LSB +: ROS_FN_W] = sel_ff[2 * out_idx];
    out_word = out_word & ROS_OUT_IMPL_MASK;
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ROS_STAT_DRIVE_LSB +: ROS_NUM_PINS] = sel_bus.drive_active;
    status_word[ROS_STAT_LEVEL_LSB +: ROS_NUM_PINS] = pin_sync_ff;
  end

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (!word_aligned || pwrite) begin
      nxt_prdata = 32'h0000_0000;
    end else if (hit_out) begin
      nxt_prdata = {16'h0000, out_word};
    end else if (hit_in_sel) begin
      nxt_prdata = {27'h000_0000, in_sel_ff};
    end else if (hit_status) begin
      nxt_prdata = status_word;
    end
  end

  // latched in the setup cycle; the master holds the address through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if ((state_ff == ROS_APB_IDLE) && setup_phase) begin
      prdata_ff <= nxt_prdata;
    end else if (access_done) begin
      prdata_ff <= 32'h0000_0000;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // output-select fields, one 5-bit field per pin

  genvar p;
  generate
    for (p = 0; p < ROS_NUM_PINS; p++) begin : g_sel
      localparam int REG_IDX = p / 2;
      localparam int FLD_LSB = (p % 2 == 1) ? ROS_HI_LSB : ROS_LO_LSB;
      localparam int LANE = p % 2;
      logic fld_wr;

      // odd pins sit in the upper byte lane, even pins in the lower
      assign fld_wr = wr_fire & hit_out & (out_idx == 3'(REG_IDX)) & pstrb[LANE];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sel_ff[p] <= ROS_FN_RESET;
        end else if (fld_wr) begin
          // only the 5 field bits are stored; 15:13 and 7:5 are dropped
          sel_ff[p] <= pwdata[FLD_LSB +: ROS_FN_W];
        end
      end
    end
  endgenerate

  // input-select field

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sel_ff <= ROS_IN_SEL_RESET;
    end else if (wr_fire && hit_in_sel && pstrb[0]) begin
      in_sel_ff <= pwdata[ROS_FN_W-1:0];
    end
  end

  // pin levels cross in through two flops before anything looks at them

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // codes past the last pin tie the peripheral input low
  always_comb begin
    nxt_periph_in = 1'b0;
    if (in_sel_ff < 5'(ROS_NUM_PINS)) begin
      nxt_periph_in = pin_sync_ff[in_sel_ff[3:0]];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_in_ff <= 1'b0;
    end else begin
      periph_in_ff <= nxt_periph_in;
    end
  end

  assign periph_in = periph_in_ff;

endmodule // ros_top

// ---- sim/ros_top_props.sv ----
/*
  ros_top_chk: port-level assertions for ros_top.
  Assumes one pclk domain and the zero-wait APB reply of the register file.
*/
`timescale 1ns/1ps
module ros_top_chk
  import ros_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [ROS_ADDR_W-1:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic [3:0] pstrb, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic [ROS_NUM_FUNCS-1:0] periph_data, // peripherals
  input wire logic [ROS_NUM_PINS-1:0] port_out, // port data
  input wire logic [ROS_NUM_PINS-1:0] port_oe, // port enable
  input wire logic [ROS_NUM_PINS-1:0] pin_in, // pin levels
  input wire logic [ROS_NUM_PINS-1:0] pin_out, // pin data
  input wire logic [ROS_NUM_PINS-1:0] pin_oe, // pin enable
  input wire logic periph_in // routed input
);
  logic wr;
  logic [31:0] pd_ff;
  assign wr = psel && penable && pready && pwrite && !pslverr;
  // copy of peripheral data as the pin flop saw it
  always_ff @(posedge pclk) begin
    pd_ff <= periph_data;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_SETUP_READY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_RSVD_ZERO: assert property (pready && !pwrite && paddr <= 12'h010 && paddr[1:0] == 2'h0
    |-> prdata[31:13] == '0 && prdata[7:5] == 3'h0) else $error("reserved bits read nonzero");
  AST_BAD_ADDR: assert property (pready && (paddr > 12'h018 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("no error on unmapped address");
  AST_RESET_QUIET: assert property (disable iff (1'b0) !presetn |-> pin_oe == '0 && !pready)
    else $error("outputs active in reset");
  AST_FIRST_EDGE: assert property ($rose(presetn) |=> pin_oe == $past(port_oe))
    else $error("pins not with port logic after reset");
  AST_FN_ZERO: assert property (wr && paddr == 12'h000 && pstrb[0] && pwdata[4:0] == 5'h00
    |-> ##2 pin_out[0] == $past(port_out[0]) && pin_oe[0] == $past(port_oe[0]))
    else $error("function zero drives pin 0");
  AST_FN_VALID: assert property (wr && paddr == 12'h000 && pstrb[1] && ROS_FUNC_IMPL[pwdata[12:8]]
    |-> ##2 pin_oe[1] && pin_out[1] == pd_ff[$past(pwdata[12:8], 2)])
    else $error("pin 1 not driven by selected function");
  AST_HI_UNUSED: assert property (wr && paddr == 12'h010 && pstrb[1] && !ROS_FUNC_IMPL[pwdata[12:8]]
    |-> ##2 pin_oe[9] == $past(port_oe[9])) else $error("unassigned function drives pin 9");
  COV_WRITE_HI: cover property (wr && paddr == 12'h010);
  COV_ERR: cover property (pready && pslverr);
  COV_RESET: cover property ($rose(presetn));
endmodule // ros_top_chk

bind ros_top ros_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .periph_data(periph_data), .port_out(port_out),
  .port_oe(port_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_in(periph_in));

// ---- sim/tb_ros_top.sv ----
/*
  tb_ros_top: random and corner stimulus for ros_top over APB.
  Assumes zero-wait APB replies and one-flop pin outputs.
*/
`timescale 1ns/1ps
module tb_ros_top;
  import ros_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b1;
  logic [3:0] sb = '0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, periph_in, er;
  logic [ROS_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, d;
  logic [3:0] pstrb = '0;
  logic [ROS_NUM_FUNCS-1:0] periph_data = '0;
  logic [ROS_NUM_PINS-1:0] port_out = '0, port_oe = '0, pin_in = '0, pin_out, pin_oe;
  ros_fn_t fsel [ROS_NUM_PINS];
  int error_cnt = 0, n_compared = 0;
  int cv [5] = '{0, 1, 20, 21, 31};
  always #2.5 pclk = ~pclk;
  ros_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_data(periph_data), .port_out(port_out),
    .port_oe(port_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .periph_in(periph_in));
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // entered just after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= w ? sb : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    // ready and data are read at the rising edge, before that edge's own updates
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // sb carries the strobes, kept apart from the data so every field code is reachable
  task automatic wr_out(input int k, input logic [31:0] wd);
    apb(1'b1, 12'(4 * k), wd);
    if (sb[0]) fsel[2 * k] = wd[4:0];
    if (sb[1]) fsel[2 * k + 1] = wd[12:8];
  endtask
  task automatic check_regs();
    for (int k = 0; k < ROS_NUM_OUT_REGS; k++) begin
      apb(1'b0, 12'(4 * k), $urandom);
      chk("out_select", {19'h0, fsel[2 * k + 1], 3'h0, fsel[2 * k]}, rd);
    end
  endtask
  function automatic logic [31:0] exp_pin(input int i);
    if (ROS_FUNC_IMPL[fsel[i]]) return {30'h0, 1'h1, periph_data[fsel[i]]};
    return {30'h0, port_oe[i], port_out[i]};
  endfunction
  function automatic logic [31:0] exp_stat();
    logic [31:0] s;
    s = '0;
    for (int i = 0; i < ROS_NUM_PINS; i++) begin
      s[ROS_STAT_DRIVE_LSB + i] = ROS_FUNC_IMPL[fsel[i]];
    end
    s[ROS_STAT_LEVEL_LSB +: ROS_NUM_PINS] = pin_in;
    return s;
  endfunction
  task automatic check_pins();
    periph_data <= $urandom;
    port_out <= 10'($urandom);
    port_oe <= 10'($urandom);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    for (int i = 0; i < ROS_NUM_PINS; i++) begin
      chk("pin", exp_pin(i), {30'h0, pin_oe[i], pin_out[i]});
    end
    @(posedge pclk);
  endtask
  initial begin
    void'($urandom(72986));
    presetn <= 1'b0;
    foreach (fsel[i]) fsel[i] = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check_regs();
    check_pins();
    $display("test reset done");
    for (int i = 0; i < ROS_NUM_PINS; i++) begin
      foreach (cv[j]) begin
        d = $urandom;
        d[(i % 2) * 8 +: 5] = 5'(cv[j]);
        sb = (i % 2) ? 4'h2 : 4'h1;
        wr_out(i / 2, d);
        check_pins();
      end
    end
    check_regs();
    $display("test corner done");
    repeat (8) begin
      repeat (5) begin
        d = $urandom;
        sb = 4'($urandom);
        wr_out($urandom_range(4), d);
      end
      check_regs();
      check_pins();
    end
    $display("test random done");
    sb = 4'hF;
    apb(1'b1, 12'h01C, $urandom);
    chk("slverr", 32'h1, {31'h0, er});
    apb(1'b1, 12'h005, $urandom);
    chk("slverr", 32'h1, {31'h0, er});
    apb(1'b0, 12'h002, $urandom);
    chk("slverr", 32'h1, {31'h0, er});
    check_regs();
    $display("test unmapped done");
    // code 31 is past the last pin, so the routed input must read low
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, ROS_OFF_INPUT_SELECT, (c < 2) ? 32'(c) : 32'h0000_001F);
      pin_in <= 10'($urandom);
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      chk("periph_in", (c < 2) ? {31'h0, pin_in[c]} : 32'h0, {31'h0, periph_in});
      @(posedge pclk);
      apb(1'b0, ROS_OFF_INPUT_SELECT, '0);
      chk("in_select", (c < 2) ? 32'(c) : 32'h0000_001F, rd);
      apb(1'b0, ROS_OFF_STATUS, '0);
      chk("status", exp_stat(), rd);
    end
    $display("test input select done");
    sb = 4'h3;
    wr_out(4, 32'h0000_0A05);
    check_pins();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (fsel[i]) fsel[i] = '0;
    @(posedge pclk);
    check_regs();
    check_pins();
    apb(1'b0, ROS_OFF_INPUT_SELECT, '0);
    chk("in_select", 32'(ROS_IN_SEL_RESET), rd);
    $display("test mid reset done");
    wrap_up();
  end
endmodule // tb_ros_top
